// [hw/wdt_defines.svh]
/*
  Constants of the watchdog / interval timer: register indices, write keys,
  field positions, reset values, counter values and count-clock divider width.
  Assumes it is included by bare name from files under hw/.
*/
// Functional notes
// - 8-bit counter increments once per selected count-clock tick while enabled.
// - counter survives own overflow reset; pin or debug-port reset clears it.
// - counter written only by word write with key 5A; reads are bytes.
// - control/status written only by word write with key A5; reads are bytes.
// - control/status survives overflow reset; pin or debug reset clears it.
// - bit 7 gates counting; zero holds the count.
// - bit 6 selects mode: 0 interval, 1 watchdog.
// - bit 4 set by watchdog-mode overflow or by a keyed write of 1 to it.
// - bit 3 set by interval-mode overflow or by a keyed write of 1 to it.
// - clock select codes pick divide by 1,4,16,32,64,256,1024,4096.
// - watchdog overflow sets flag, pulses power-on reset, keeps counting.
// - interval overflow sets flag, pulses interrupt request, keeps counting.
// - interval mode ignores the wrap right after software loads FF.
// - in standby, pin level change starts counting; overflow resumes clocks, no flag.
// - after wake count from zero; standby still selected at 80 re-enters standby.
// - standby ended by reset does not count.
// - multiplier write pauses and starts counting; overflow resumes clocks, no flag.
// - after frequency-change overflow the counter clears to zero; it stops there while bit 7 is zero.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ****************************************
// register map and keys
// ****************************************
`define WDT_IDX_COUNT   1'b0
`define WDT_IDX_CSR     1'b1
`define WDT_KEY_COUNT   8'h5A
`define WDT_KEY_CSR     8'hA5

// ****************************************
// control/status fields
// ****************************************
`define WDT_BIT_EN      7
`define WDT_BIT_MODE    6
`define WDT_BIT_WATCHDOG_OVERFLOW_FLAG    4
`define WDT_BIT_INTERVAL_OVERFLOW_FLAG    3
`define WDT_CKS_HI      2
`define WDT_CKS_LO      0
`define WDT_CSR_WMASK   8'hDF
`define WDT_RST_VAL     8'h00

// ****************************************
// counter values
// ****************************************
`define WDT_CNT_ZERO    8'h00
`define WDT_CNT_TOP     8'hFF
`define WDT_CNT_REENTER 8'h80

// ****************************************
// count clock divider
// ****************************************
`define WDT_DIV_W       12
`define WDT_DIV_ZERO    12'h000
`define WDT_DIV_ONE     12'h001

`endif

// [hw/wdt_pkg.sv]
/*
  Types of the watchdog / interval timer: access sizes, sequencer states
  and the packed write request.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wdt_pkg;

  // ****************************************
  // access size and write request
  // ****************************************
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } acc_size_e;

  typedef struct packed {
    logic      wrEn;
    acc_size_e size;
    logic      idx;
    logic [15:0] data;
  } wr_req_s;

  // ****************************************
  // sequencer states, gray along the path
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_WAIT   = 3'h1,
    ST_SETTLE = 3'h3,
    ST_WAKE   = 3'h2,
    ST_LOCK   = 3'h6,
    ST_PLL    = 3'h4
  } wdt_state_e;

endpackage

// [hw/wdt_prescaler.sv]
/*
  Count-clock divider: one-cycle tick at the peripheral clock divided
  by 1, 4, 16, 32, 64, 256, 1024 or 4096.
  Assumes run and sel come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"

module wdt_prescaler (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  import wdt_pkg::*;

  logic [`WDT_DIV_W-1:0] div_reg;
  logic [`WDT_DIV_W-1:0] mask;

  // ****************************************
  // divider chain
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_reg <= `WDT_DIV_ZERO;
    end else if (!run) begin
      div_reg <= `WDT_DIV_ZERO;
    end else begin
      div_reg <= div_reg + `WDT_DIV_ONE;
    end
  end

  always_comb begin
    case (sel)
      3'h0:    mask = 12'h000;
      3'h1:    mask = 12'h003;
      3'h2:    mask = 12'h00F;
      3'h3:    mask = 12'h01F;
      3'h4:    mask = 12'h03F;
      3'h5:    mask = 12'h0FF;
      3'h6:    mask = 12'h3FF;
      default: mask = 12'hFFF;
    endcase
  end

  assign tick = run && ((div_reg & mask) == mask);

endmodule // wdt_prescaler
`default_nettype wire

// [hw/wdt_key_decoder.sv]
/*
  Key check of register writes: only a word write whose upper byte is
  the key of the addressed register yields a load strobe.
  Assumes the request is one cycle long and on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"

module wdt_key_decoder (
  input  wire wdt_pkg::wr_req_s req,
  output logic                  countLoad,
  output logic                  csrLoad
);
  import wdt_pkg::*;

  logic wordWr;

  // ****************************************
  // key match
  // ****************************************
  assign wordWr    = req.wrEn && (req.size == SZ_WORD);
  assign countLoad = wordWr && (req.idx == `WDT_IDX_COUNT)
                     && (req.data[15:8] == `WDT_KEY_COUNT);
  assign csrLoad   = wordWr && (req.idx == `WDT_IDX_CSR)
                     && (req.data[15:8] == `WDT_KEY_CSR);

endmodule // wdt_key_decoder
`default_nettype wire

// [hw/watchdog_interval_timer.sv]
/*
  Watchdog / interval timer: counter, control/status register, overflow
  events and the settling sequencer for standby wake and ratio change.
  Assumes bus, standby and pll strobes come from clk_sys logic; wake
  pins are asynchronous; debugReset is a synchronous clear request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"

module watchdog_interval_timer (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             debugReset,
  input  wire wdt_pkg::wr_req_s busWr,
  input  wire logic             rdEn,
  input  wire logic             rdIdx,
  output logic [7:0]            rdData,
  input  wire logic             standbyEnter,
  input  wire logic             standbySelect,
  input  wire logic [8:0]       wakePins,
  input  wire logic             pllWrite,
  output logic                  powerOnReset,
  output logic                  intervalIrq,
  output logic                  clockResume,
  output logic                  cpuPause,
  output logic                  standbyReenter
);
  import wdt_pkg::*;

  logic [7:0] count_reg;
  logic [7:0] csr_reg;
  logic [7:0] csr_next;
  logic       skipFf_reg;
  wdt_state_e state_reg;
  logic [8:0] wakeMeta_reg;
  logic [8:0] wakeSync_reg;
  logic [8:0] wakePrev_reg;
  logic [2:0] wakeArm_reg;
  logic       countLoad;
  logic       csrLoad;
  logic       countRun;
  logic       tick;
  logic       wrap;
  logic       normalOvf;
  logic       wdMode;
  logic       wakeChange;

  // ****************************************
  // write keys and count clock
  // ****************************************
  wdt_key_decoder u_keys (
    .req       (busWr),
    .countLoad (countLoad),
    .csrLoad   (csrLoad)
  );

  wdt_prescaler u_div (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (countRun),
    .sel     (csr_reg[`WDT_CKS_HI:`WDT_CKS_LO]),
    .tick    (tick)
  );

  // ****************************************
  // wake pin synchroniser
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wakeMeta_reg <= 9'h000;
      wakeSync_reg <= 9'h000;
      wakePrev_reg <= 9'h000;
      wakeArm_reg  <= 3'h0;
    end else begin
      wakeMeta_reg <= wakePins;
      wakeSync_reg <= wakeMeta_reg;
      wakePrev_reg <= wakeSync_reg;
      wakeArm_reg  <= {wakeArm_reg[1:0], 1'b1};
    end
  end

  // no change reported until the pipe holds real pin samples
  assign wakeChange = wakeArm_reg[2] && (wakeSync_reg != wakePrev_reg);

  // ****************************************
  // run and overflow decode
  // ****************************************
  assign wdMode = csr_reg[`WDT_BIT_MODE];

  always_comb begin
    case (state_reg)
      ST_IDLE:   countRun = csr_reg[`WDT_BIT_EN];
      ST_SETTLE: countRun = 1'b1;
      ST_WAKE:   countRun = 1'b1;
      ST_PLL:    countRun = 1'b1;
      default:   countRun = 1'b0;
    endcase
  end

  assign wrap      = tick && (count_reg == `WDT_CNT_TOP);
  assign normalOvf = wrap && (state_reg == ST_IDLE)
                     && !(skipFf_reg && !wdMode);

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg <= `WDT_RST_VAL;
    end else if (debugReset) begin
      count_reg <= `WDT_RST_VAL;
    end else if (countLoad) begin
      count_reg <= busWr.data[7:0];
    end else if (wrap && (state_reg == ST_PLL)) begin
      count_reg <= `WDT_CNT_ZERO;
    end else if (tick) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // ****************************************
  // interval FF exception
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      skipFf_reg <= 1'b0;
    end else if (debugReset) begin
      skipFf_reg <= 1'b0;
    end else if (countLoad) begin
      skipFf_reg <= (busWr.data[7:0] == `WDT_CNT_TOP);
    end else if (tick) begin
      skipFf_reg <= 1'b0;
    end
  end

  // ****************************************
  // control/status register
  // ****************************************
  always_comb begin
    csr_next = csr_reg;
    if (csrLoad) begin
      csr_next = busWr.data[7:0] & `WDT_CSR_WMASK;
    end
    if (normalOvf && wdMode) begin
      csr_next[`WDT_BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
    end
    if (normalOvf && !wdMode) begin
      csr_next[`WDT_BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      csr_reg <= `WDT_RST_VAL;
    end else if (debugReset) begin
      csr_reg <= `WDT_RST_VAL;
    end else begin
      csr_reg <= csr_next;
    end
  end

  // ****************************************
  // overflow events
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      powerOnReset <= 1'b0;
      intervalIrq  <= 1'b0;
    end else begin
      powerOnReset <= normalOvf && wdMode && !debugReset;
      intervalIrq  <= normalOvf && !wdMode && !debugReset;
    end
  end

  // ****************************************
  // settling sequencer
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else if (debugReset) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (standbyEnter) begin
            state_reg <= ST_WAIT;
          end else if (pllWrite) begin
            state_reg <= ST_PLL;
          end
        end
        ST_WAIT: begin
          if (wakeChange) begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (wrap) begin
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (!standbySelect) begin
            state_reg <= ST_IDLE;
          end else if (count_reg == `WDT_CNT_REENTER) begin
            state_reg <= ST_LOCK;
          end
        end
        ST_PLL: begin
          if (wrap) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_LOCK;
        end
      endcase
    end
  end

  // ****************************************
  // clock generator handshakes
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clockResume    <= 1'b0;
      cpuPause       <= 1'b0;
      standbyReenter <= 1'b0;
    end else begin
      clockResume    <= wrap && !debugReset
                        && ((state_reg == ST_SETTLE) || (state_reg == ST_PLL));
      cpuPause       <= !debugReset && (((state_reg == ST_IDLE) && pllWrite && !standbyEnter)
                        || ((state_reg == ST_PLL) && !wrap));
      standbyReenter <= !debugReset && (state_reg == ST_WAKE) && standbySelect
                        && (count_reg == `WDT_CNT_REENTER);
    end
  end

  // ****************************************
  // byte read port
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData <= `WDT_RST_VAL;
    end else if (rdEn) begin
      if (rdIdx == `WDT_IDX_COUNT) begin
        rdData <= count_reg;
      end else begin
        rdData <= csr_reg;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn || debugReset);

  chk_hold_stopped: assert property (
    (state_reg == ST_IDLE) && !csr_reg[`WDT_BIT_EN] && !countLoad
    |=> count_reg == $past(count_reg))
    else $error("count moved while stopped");

  chk_bad_key: assert property (
    busWr.wrEn && (busWr.data[15:8] != `WDT_KEY_COUNT) && !countRun
    |=> count_reg == $past(count_reg))
    else $error("count changed without key");

  chk_load_count: assert property (
    countLoad |=> count_reg == $past(busWr.data[7:0]))
    else $error("keyed count write lost");

  chk_wd_overflow: assert property (
    normalOvf && wdMode
    |=> powerOnReset && csr_reg[`WDT_BIT_WATCHDOG_OVERFLOW_FLAG] && !intervalIrq)
    else $error("watchdog overflow not signalled");

  chk_int_overflow: assert property (
    normalOvf && !wdMode && !csrLoad
    |=> intervalIrq && csr_reg[`WDT_BIT_INTERVAL_OVERFLOW_FLAG] && !powerOnReset)
    else $error("interval overflow not signalled");

  chk_ff_skip: assert property (
    (state_reg == ST_IDLE) && wrap && skipFf_reg && !wdMode
    |=> !intervalIrq)
    else $error("interval overflow right after FF load");

  chk_settle_flag: assert property (
    (state_reg == ST_SETTLE) && wrap && !csrLoad
    |=> clockResume && (csr_reg == $past(csr_reg)) ##1 !clockResume)
    else $error("standby settle overflow wrong");

  chk_pll_stop: assert property (
    (state_reg == ST_PLL) && wrap && !countLoad
    |=> (state_reg == ST_IDLE) && (count_reg == `WDT_CNT_ZERO) && clockResume)
    else $error("ratio change overflow did not stop at zero");

  chk_reenter: assert property (
    (state_reg == ST_WAKE) && standbySelect && (count_reg == `WDT_CNT_REENTER)
    |=> standbyReenter ##1 (state_reg == ST_LOCK) && !countRun)
    else $error("standby re-entry missed");

  chk_div_one: assert property (
    countRun && (csr_reg[`WDT_CKS_HI:`WDT_CKS_LO] == 3'h0) |-> tick)
    else $error("divide by one missed a tick");

  cov_wd_reset: cover property (normalOvf && wdMode);
  cov_irq: cover property (normalOvf && !wdMode);
  cov_wake: cover property ((state_reg == ST_SETTLE) && wrap);
  cov_pll: cover property ((state_reg == ST_PLL) && wrap);

endmodule // watchdog_interval_timer
`default_nettype wire

// [tb/wdt_far_end.sv]
/*
  Far-end model: power controller and clock generator strobes, plus event
  counters for the reset logic, interrupt controller and clock generator.
  Assumes the timer's event outputs are registered one-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module wdt_far_end (
  input  wire logic clk_sys,
  input  wire logic powerOnReset,
  input  wire logic intervalIrq,
  input  wire logic clockResume,
  input  wire logic standbyReenter,
  output logic      standbyEnter,
  output logic      pllWrite
);
  int porCnt = 0;
  int irqCnt = 0;
  int resumeCnt = 0;
  int reenterCnt = 0;

  // ****************************************
  // event counters
  // ****************************************
  always @(posedge clk_sys) begin
    if (powerOnReset === 1'b1) porCnt++;
    if (intervalIrq === 1'b1) irqCnt++;
    if (clockResume === 1'b1) resumeCnt++;
    if (standbyReenter === 1'b1) reenterCnt++;
  end

  // ****************************************
  // strobes, driven at the falling edge
  // ****************************************
  initial begin
    standbyEnter = 1'b0;
    pllWrite = 1'b0;
  end

  task automatic sleepCmd();
    @(negedge clk_sys);
    standbyEnter = 1'b1;
    @(negedge clk_sys);
    standbyEnter = 1'b0;
  endtask

  task automatic pllCmd();
    @(negedge clk_sys);
    pllWrite = 1'b1;
    @(negedge clk_sys);
    pllWrite = 1'b0;
  endtask
endmodule // wdt_far_end
`default_nettype wire

// [tb/watchdog_interval_timer_tb.sv]
/*
  Self-checking bench of the watchdog / interval timer: keyed word writes,
  byte reads, divider rates, overflow events, standby and ratio-change settling.
  Assumes wdt_pkg, the design files and wdt_far_end are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module watchdog_interval_timer_tb;
  import wdt_pkg::*;
  logic             clk_sys;
  logic             resetn;
  logic             debugReset;
  wr_req_s          busWr;
  logic             rdEn;
  logic             rdIdx;
  logic [7:0]       rdData;
  logic             standbyEnter;
  logic             standbySelect;
  logic [8:0]       wakePins;
  logic             pllWrite;
  logic             powerOnReset;
  logic             intervalIrq;
  logic             clockResume;
  logic             cpuPause;
  logic             standbyReenter;
  int               errorCnt = 0;
  int               nChecks = 0;

  watchdog_interval_timer u_dut (.clk_sys(clk_sys), .resetn(resetn), .debugReset(debugReset), .busWr(busWr),
    .rdEn(rdEn), .rdIdx(rdIdx), .rdData(rdData), .standbyEnter(standbyEnter), .standbySelect(standbySelect),
    .wakePins(wakePins), .pllWrite(pllWrite), .powerOnReset(powerOnReset), .intervalIrq(intervalIrq),
    .clockResume(clockResume), .cpuPause(cpuPause), .standbyReenter(standbyReenter));

  wdt_far_end u_far (.clk_sys(clk_sys), .powerOnReset(powerOnReset), .intervalIrq(intervalIrq),
    .clockResume(clockResume), .standbyReenter(standbyReenter), .standbyEnter(standbyEnter), .pllWrite(pllWrite));

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #500000;
    errorCnt++;
    printVerdict();
  end

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input acc_size_e sz, input logic idx, input logic [15:0] d);
    @(negedge clk_sys);
    busWr = {1'b1, sz, idx, d};
    @(negedge clk_sys);
    busWr.wrEn = 1'b0;
  endtask

  task automatic rd(input logic idx, output logic [7:0] v);
    @(negedge clk_sys);
    rdEn = 1'b1;
    rdIdx = idx;
    @(negedge clk_sys);
    rdEn = 1'b0;
    v = rdData;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkN(input int got, input int exp);
    nChecks++;
    if (got != exp) begin
      errorCnt++;
      $display("mismatch at %0t: event count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic expReg(input logic idx, input logic [7:0] exp);
    logic [7:0] v;
    rd(idx, v);
    check8(v, exp);
  endtask

  task automatic printVerdict();
    $display("errors %0d checks %0d", errorCnt, nChecks);
    if (errorCnt == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    int divs [8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
    logic [7:0] a;
    logic [7:0] b;
    int n0;
    int p0;
    int r0;
    resetn = 1'b0;
    debugReset = 1'b0;
    busWr = '0;
    rdEn = 1'b0;
    rdIdx = 1'b0;
    standbySelect = 1'b0;
    wakePins = '0;
    cyc(4);
    resetn = 1'b1;
    expReg(1'b0, 8'h00);
    expReg(1'b1, 8'h00);
    wr(SZ_WORD, 1'b0, 16'h5A12);
    expReg(1'b0, 8'h12);
    wr(SZ_BYTE, 1'b0, 16'h5A77);
    wr(SZ_LONG, 1'b0, 16'h5A77);
    wr(SZ_WORD, 1'b0, 16'hA577);
    wr(SZ_WORD, 1'b1, 16'h5A07);
    expReg(1'b0, 8'h12);
    expReg(1'b1, 8'h00);
    wr(SZ_WORD, 1'b1, 16'hA527);
    expReg(1'b1, 8'h07);
    cyc(50);
    expReg(1'b0, 8'h12);
    for (int i = 0; i < 8; i++) begin
      wr(SZ_WORD, 1'b1, {8'hA5, 5'h00, i[2:0]});
      wr(SZ_WORD, 1'b0, 16'h5A00);
      wr(SZ_WORD, 1'b1, {8'hA5, 5'h10, i[2:0]});
      cyc(3);
      rd(1'b0, a);
      cyc(2 * divs[i] - 2);
      rd(1'b0, b);
      check8(b - a, 8'h02);
    end
    wr(SZ_WORD, 1'b1, 16'hA500);
    wr(SZ_WORD, 1'b0, 16'h5AFE);
    n0 = u_far.irqCnt;
    p0 = u_far.porCnt;
    wr(SZ_WORD, 1'b1, 16'hA580);
    cyc(10);
    checkN(u_far.irqCnt, n0 + 1);
    expReg(1'b1, 8'h88);
    checkN(u_far.porCnt, p0);
    wr(SZ_WORD, 1'b1, 16'hA500);
    wr(SZ_WORD, 1'b0, 16'h5AFF);
    wr(SZ_WORD, 1'b1, 16'hA580);
    cyc(10);
    checkN(u_far.irqCnt, n0 + 1);
    expReg(1'b1, 8'h80);
    cyc(260);
    checkN(u_far.irqCnt, n0 + 2);
    wr(SZ_WORD, 1'b1, 16'hA500);
    wr(SZ_WORD, 1'b0, 16'h5AFF);
    wr(SZ_WORD, 1'b1, 16'hA5C0);
    cyc(5);
    checkN(u_far.porCnt, p0 + 1);
    checkN(u_far.irqCnt, n0 + 2);
    expReg(1'b1, 8'hD0);
    rd(1'b0, a);
    cyc(8);
    rd(1'b0, b);
    check8(b - a, 8'h0A);
    for (int i = 0; i < 4; i++) begin
      cyc(200);
      wr(SZ_WORD, 1'b0, 16'h5A00);
    end
    checkN(u_far.porCnt, p0 + 1);
    @(negedge clk_sys);
    debugReset = 1'b1;
    @(negedge clk_sys);
    debugReset = 1'b0;
    expReg(1'b0, 8'h00);
    expReg(1'b1, 8'h00);
    wr(SZ_WORD, 1'b0, 16'h5AF0);
    r0 = u_far.resumeCnt;
    u_far.pllCmd();
    cyc(2);
    check8({7'h00, cpuPause}, 8'h01);
    cyc(30);
    checkN(u_far.resumeCnt, r0 + 1);
    check8({7'h00, cpuPause}, 8'h00);
    cyc(20);
    expReg(1'b0, 8'h00);
    expReg(1'b1, 8'h00);
    standbySelect = 1'b1;
    wr(SZ_WORD, 1'b0, 16'h5AF0);
    u_far.sleepCmd();
    cyc(10);
    expReg(1'b0, 8'hF0);
    wakePins[0] = 1'b1;
    cyc(30);
    checkN(u_far.resumeCnt, r0 + 2);
    expReg(1'b1, 8'h00);
    cyc(140);
    checkN(u_far.reenterCnt, 1);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    u_far.sleepCmd();
    cyc(5);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(5);
    wakePins[0] = 1'b0;
    cyc(35);
    checkN(u_far.resumeCnt, r0 + 2);
    expReg(1'b0, 8'h00);
    printVerdict();
  end
endmodule // watchdog_interval_timer_tb
`default_nettype wire
